// *** rtl/outgoing_switch_unit_regs.vh ***
// register map, fields, reset values and limits of the outgoing switch unit
`ifndef OUTGOING_SWITCH_UNIT_REGS_VH
`define OUTGOING_SWITCH_UNIT_REGS_VH

// register indices; byte address is four times the index
`define OSU_IDX_CONFIG 10'h048
`define OSU_IDX_EVENT 10'h049
`define OSU_IDX_RAM_INDEX 10'h04a
`define OSU_IDX_RAM_PAYLOAD 10'h04b

// page_update_config fields
`define OSU_CFG_AUTO_COPY 4
`define OSU_CFG_SWAP_WAIT_IRQ_EN 3
`define OSU_CFG_COPY_DONE_IRQ_EN 2
`define OSU_CFG_SWAP_WAIT_STATE 1
`define OSU_CFG_COPY_ACTIVE_STATE 0

// switch_event_and_copy fields
`define OSU_EVT_SWAP_WAIT 1
`define OSU_EVT_COPY_DONE 0

// switch_ram_index / switch_ram_payload fields
`define OSU_IDX_READ_NOT_WRITE 15
`define OSU_PAY_VALID 15
`define OSU_PAY_RESERVED 14

// reset values
`define OSU_CONFIG_RESET 3'h0
`define OSU_RAM_INDEX_RESET 16'h0000
`define OSU_PAYLOAD_RESET 15'h0000

// frame geometry and legal index limits
`define OSU_ROW_BYTES 14'd1080
`define OSU_LAST_ROW 4'h8
`define OSU_DS0_LAST 14'h25f7
`define OSU_COLUMN_LAST 14'h0437
`define OSU_PAGE_SIZE 15'd9720

`endif

// *** rtl/outgoing_time_switch_memory.v ***
// outgoing time-slot switch: connection ram pages, page copy, swap and host access
//
// Contract
// RL1 - auto-copy on page change when enabled
// RL2 - event register write starts page copy
// RL3 - host avoids ram access during copy
// RL4 - swap-wait state high until swap done
// RL5 - copy-active state high while copying
// RL6 - swap-wait event on any state edge
// RL7 - copy-done event on copy-active fall
// RL8 - enables gate each event onto interrupt
// RL9 - index write launches ram read or write
// RL10 - host loads payload before write launch
// RL11 - host spaces ram accesses four clocks
// RL12 - read data valid within eight clocks
// RL13 - destination index selects output byte entry
// RL14 - entry holds source index to emit
// RL15 - output bytes numbered row by row
// RL16 - valid set by read, cleared on read
// RL17 - software preserves reserved payload bit
// RL18 - host writes touch off-line page only
`include "outgoing_switch_unit_regs.vh"

module outgoing_time_switch_memory (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [11:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  output reg [31:0] dat_o,
  output wire ack_o,
  output wire irq_o,
  input wire page_select_input_i,
  input wire column_mode_i,
  input wire frame_start_i,
  input wire [3:0] out_row_i,
  input wire [10:0] out_col_i,
  output reg [13:0] src_slot_index_o,
  output wire online_page_o
);

  // both pages in one flop array: page 0 at 0, page 1 at page size
  reg [13:0] conn_mem [0:19439];

  reg ack_r;
  reg [2:0] cfg_r;
  reg online_r;
  reg sel_seen_r;
  reg swap_wait_prev_r;
  reg copy_active_r;
  reg copy_prev_r;
  reg [13:0] copy_idx_r;
  reg swap_evt_r;
  reg copy_evt_r;
  reg [15:0] ram_index_r;
  reg [14:0] payload_r;
  reg valid_r;
  reg launch_r;
  reg read_pend_r;

  wire acc;
  wire wr;
  wire rd;
  wire [9:0] reg_idx;
  wire [15:0] wmask;
  wire [15:0] wdata;
  wire swap_wait;
  wire swap_now;
  wire copy_start;
  wire [13:0] last_idx;
  wire [13:0] dest_pos;
  wire host_idx_ok;
  wire [13:0] host_idx;
  reg [31:0] rd_nxt;

  // register hits, decoded once and shared
  wire hit_cfg;
  wire hit_evt;
  wire hit_index;
  wire hit_payload;

  // frame position guard
  wire pos_ok;

  // event set and clear terms
  wire swap_edge;
  wire copy_fall;
  wire clr_swap;
  wire clr_copy;

  // map page and index to a flat array slot
  function [14:0] slot;
    input page;
    input [13:0] idx;
    begin
      slot = page ? ({1'b0, idx} + `OSU_PAGE_SIZE) : {1'b0, idx};
    end
  endfunction

  // legal index for the current mode
  function in_range;
    input [13:0] idx;
    input column;
    begin
      in_range = column ? (idx <= `OSU_COLUMN_LAST) : (idx <= `OSU_DS0_LAST);
    end
  endfunction

  // row by row numbering; only meaningful on a legal row and column
  function [13:0] byte_pos;
    input [3:0] row;
    input [10:0] col;
    reg [13:0] row_base;
    begin
      row_base = {10'h000, row} * `OSU_ROW_BYTES;
      byte_pos = row_base + {3'h0, col};
    end
  endfunction

  // a row or column outside the frame could wrap into a legal index
  function pos_legal;
    input [3:0] row;
    input [10:0] col;
    begin
      pos_legal = (row <= `OSU_LAST_ROW) & ({3'h0, col} < `OSU_ROW_BYTES);
    end
  endfunction

  // wishbone classic: ack one cycle after the strobe, side effects on the ack edge
  assign acc = cyc_i & stb_i & ack_r;
  assign wr = acc & we_i;
  assign rd = acc & ~we_i;
  assign ack_o = ack_r;
  assign reg_idx = adr_i[11:2];
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wdata = dat_i[15:0];

  assign hit_cfg = reg_idx == `OSU_IDX_CONFIG;
  assign hit_evt = reg_idx == `OSU_IDX_EVENT;
  assign hit_index = reg_idx == `OSU_IDX_RAM_INDEX;
  assign hit_payload = reg_idx == `OSU_IDX_RAM_PAYLOAD;

  assign last_idx = column_mode_i ? `OSU_COLUMN_LAST : `OSU_DS0_LAST;
  assign swap_wait = sel_seen_r != online_r; // RL4

  // no swap during a copy, or the copy would mix two pages
  assign swap_now = swap_wait & frame_start_i & ~copy_active_r;

  // any write to the event register copies, whatever the auto bit says
  assign copy_start = (wr & hit_evt)
                    | (swap_now & cfg_r[`OSU_CFG_AUTO_COPY - 2]); // RL1 RL2

  assign pos_ok = pos_legal(out_row_i, out_col_i); // RL15
  assign dest_pos = byte_pos(out_row_i, out_col_i); // RL15

  assign swap_edge = swap_wait != swap_wait_prev_r; // RL6
  assign copy_fall = copy_prev_r & ~copy_active_r; // RL7

  // clear by read or by a written one; the set term still wins
  assign clr_swap = hit_evt & (rd | (wr & wdata[`OSU_EVT_SWAP_WAIT] & sel_i[0]));
  assign clr_copy = hit_evt & (rd | (wr & wdata[`OSU_EVT_COPY_DONE] & sel_i[0]));
  assign host_idx = ram_index_r[13:0];
  assign host_idx_ok = in_range(host_idx, column_mode_i); // RL13
  assign online_page_o = online_r;

  assign irq_o = (swap_evt_r & cfg_r[`OSU_CFG_SWAP_WAIT_IRQ_EN - 2])
               | (copy_evt_r & cfg_r[`OSU_CFG_COPY_DONE_IRQ_EN - 2]); // RL8

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i & stb_i & ~ack_r;
    end
  end

  // read mux
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (reg_idx)
      `OSU_IDX_CONFIG: begin
        rd_nxt[4:2] = cfg_r;
        rd_nxt[`OSU_CFG_SWAP_WAIT_STATE] = swap_wait; // RL4
        rd_nxt[`OSU_CFG_COPY_ACTIVE_STATE] = copy_active_r; // RL5
      end
      `OSU_IDX_EVENT: begin
        rd_nxt[`OSU_EVT_SWAP_WAIT] = swap_evt_r;
        rd_nxt[`OSU_EVT_COPY_DONE] = copy_evt_r;
      end
      `OSU_IDX_RAM_INDEX: begin
        rd_nxt[15:0] = ram_index_r;
      end
      `OSU_IDX_RAM_PAYLOAD: begin
        rd_nxt[15:0] = {valid_r, payload_r};
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i & stb_i & ~ack_r & ~we_i) begin
      dat_o <= rd_nxt;
    end else begin
      // only the ack cycle may show data
      dat_o <= 32'h0000_0000;
    end
  end

  // configuration: enables and auto-copy bit, states are read-only
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= `OSU_CONFIG_RESET;
    end else if (wr & hit_cfg) begin
      cfg_r <= (cfg_r & ~wmask[4:2]) | (wdata[4:2] & wmask[4:2]);
    end
  end

  // index register; every write to it with sel_i[1] or sel_i[0] set launches one access
  always @(posedge clk_i) begin
    if (rst_i) begin
      ram_index_r <= `OSU_RAM_INDEX_RESET;
      launch_r <= 1'b0;
    end else begin
      launch_r <= 1'b0;
      if (wr & hit_index) begin
        // unused bit 14 always reads zero
        ram_index_r <= ((ram_index_r & ~wmask) | (wdata & wmask)) & 16'hbfff;
        launch_r <= |sel_i[1:0]; // RL9
      end
    end
  end

  // page select tracking and swap
  always @(posedge clk_i) begin
    if (rst_i) begin
      sel_seen_r <= 1'b0;
      online_r <= 1'b0;
      swap_wait_prev_r <= 1'b0;
    end else begin
      sel_seen_r <= page_select_input_i;
      swap_wait_prev_r <= swap_wait;
      if (swap_now) begin
        online_r <= sel_seen_r; // RL4
      end
    end
  end

  // page copy engine, one entry per clock; restarts if retriggered
  always @(posedge clk_i) begin
    if (rst_i) begin
      copy_active_r <= 1'b0;
      copy_prev_r <= 1'b0;
      copy_idx_r <= 14'h0000;
    end else begin
      copy_prev_r <= copy_active_r;
      if (copy_start) begin
        copy_active_r <= 1'b1; // RL5
        copy_idx_r <= 14'h0000;
      end else if (copy_active_r) begin
        if (copy_idx_r == last_idx) begin
          copy_active_r <= 1'b0; // RL5
        end
        copy_idx_r <= copy_idx_r + 14'h0001;
      end
    end
  end

  // swap-wait event: set wins over clear, so no edge is lost to a read
  always @(posedge clk_i) begin
    if (rst_i) begin
      swap_evt_r <= 1'b0;
    end else if (swap_edge) begin
      swap_evt_r <= 1'b1; // RL6
    end else if (clr_swap) begin
      swap_evt_r <= 1'b0; // RL6
    end
  end

  // copy-done event: set wins over clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      copy_evt_r <= 1'b0;
    end else if (copy_fall) begin
      copy_evt_r <= 1'b1; // RL7
    end else if (clr_copy) begin
      copy_evt_r <= 1'b0; // RL7
    end
  end

  // connection ram: copy has priority; host write dropped if it collides
  always @(posedge clk_i) begin
    if (copy_active_r) begin
      conn_mem[slot(~online_r, copy_idx_r)] <= conn_mem[slot(online_r, copy_idx_r)]; // RL1
    end else if (launch_r & ~ram_index_r[`OSU_IDX_READ_NOT_WRITE] & host_idx_ok) begin
      conn_mem[slot(~online_r, host_idx)] <= payload_r[13:0]; // RL18 RL14
    end
  end

  // payload register and indirect read return
  always @(posedge clk_i) begin
    if (rst_i) begin
      payload_r <= `OSU_PAYLOAD_RESET;
      read_pend_r <= 1'b0;
    end else begin
      read_pend_r <= launch_r & ram_index_r[`OSU_IDX_READ_NOT_WRITE]; // RL9

      if (read_pend_r) begin
        // out-of-range index reads back as zero
        payload_r[13:0] <= host_idx_ok ? conn_mem[slot(~online_r, host_idx)] : 14'h0000; // RL12
      end else if (wr & hit_payload) begin
        payload_r <= (payload_r & ~wmask[14:0]) | (wdata[14:0] & wmask[14:0]);
      end
    end
  end

  // valid flag: a returning read wins over the clearing read
  always @(posedge clk_i) begin
    if (rst_i) begin
      valid_r <= 1'b0;
    end else if (read_pend_r) begin
      valid_r <= 1'b1; // RL16
    end else if (rd & hit_payload) begin
      valid_r <= 1'b0; // RL16
    end
  end

  // switching lookup on the on-line page
  always @(posedge clk_i) begin
    if (rst_i) begin
      src_slot_index_o <= 14'h0000;
    end else if (pos_ok & in_range(dest_pos, column_mode_i)) begin
      src_slot_index_o <= conn_mem[slot(online_r, dest_pos)]; // RL13 RL14
    end else begin
      src_slot_index_o <= 14'h0000;
    end
  end

endmodule // outgoing_time_switch_memory

// *** bench/osu_chk.sv ***
// port assertions of the outgoing switch unit
module osu_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic irq_o,
  input wire logic frame_start_i,
  input wire logic online_page_o,
  input wire logic column_mode_i,
  input wire logic [31:0] dat_o,
  input wire logic [3:0] out_row_i,
  input wire logic [13:0] src_slot_index_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_one; ack_o |=> !ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held too long");
  property p_ack_req; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack missing");
  property p_ack_why; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_ack_why: assert property (p_ack_why) else $error("ack without request");
  property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data off cycle");
  property p_irq_rst; $fell(rst_i) |-> !irq_o; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
  property p_swap; $changed(online_page_o) |-> $past(frame_start_i); endproperty
  a_swap: assert property (p_swap) else $error("swap off frame start");
  property p_col; column_mode_i && out_row_i != 4'h0 |=> src_slot_index_o == 14'h0; endproperty
  a_col: assert property (p_col) else $error("column range");
  property p_row; out_row_i > 4'h8 |=> src_slot_index_o == 14'h0; endproperty
  a_row: assert property (p_row) else $error("row range");
  c_irq: cover property (irq_o);
  c_swap: cover property ($changed(online_page_o));
  c_col: cover property (column_mode_i && out_row_i != 4'h0);
endmodule // osu_chk

// *** bench/bus_far_end.sv ***
// far end model: byte position, frame pulse, page select
module bus_far_end (
  input wire logic clk_i,
  input wire logic fs_req_i,
  input wire logic psel_req_i,
  input wire logic [3:0] row_req_i,
  input wire logic [10:0] col_req_i,
  output logic frame_start_o = 1'h0,
  output logic page_select_o = 1'h0,
  output logic [3:0] row_o = 4'h0,
  output logic [10:0] col_o = 11'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // registered, so every change lands just after an edge
  always @(posedge clk_i) begin
    frame_start_o <= fs_req_i;
    page_select_o <= psel_req_i;
    row_o <= row_req_i;
    col_o <= col_req_i;
  end
endmodule // bus_far_end

// *** bench/testbench.sv ***
// self-checking bench of the outgoing switch unit
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic [11:0] adr_i = 12'h0;
  logic [31:0] dat_i = 32'h0, r, s = 32'd85661;
  logic [3:0] sel_i = 4'h0, row_q = 4'h0, out_row_i;
  logic fs_q = 1'h0, ps_q = 1'h0, column_mode_i = 1'h1;
  logic [10:0] col_q = 11'h0, out_col_i;
  logic [13:0] dv[4], ix;
  wire [31:0] dat_o;
  wire ack_o, irq_o, frame_start_i, page_select_input_i, online_page_o;
  wire [13:0] src_slot_index_o;
  int n_fail = 0, checks = 0;
  always #50 clk_i = ~clk_i;
  outgoing_time_switch_memory DUT (.*);
  bus_far_end far (.clk_i, .fs_req_i(fs_q), .psel_req_i(ps_q), .row_req_i(row_q),
    .col_req_i(col_q), .frame_start_o(frame_start_i), .page_select_o(page_select_input_i),
    .row_o(out_row_i), .col_o(out_col_i));
  function automatic [31:0] lfsr(input [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input [31:0] g, input [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input w, input [9:0] a, input [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'h1; stb_i <= 1'h1; we_i <= w; adr_i <= {a, 2'h0};
    dat_i <= {16'h0, d}; sel_i <= 4'h3;
    @(posedge clk_i);
    while (ack_o !== 1'h1) @(posedge clk_i);
    r = dat_o;
    cyc_i <= 1'h0; stb_i <= 1'h0;
  endtask
  task automatic rd(input [9:0] a, input [31:0] e);
    wb(1'h0, a, 16'h0);
    chk(r, e);
  endtask
  task automatic wr(input [9:0] a, input [15:0] d);
    wb(1'h1, a, d);
  endtask
  task automatic irq(input e);
    @(negedge clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask
  // one frame pulse, then time for the swap to land
  task automatic frame;
    fs_q <= 1'h1;
    @(posedge clk_i);
    fs_q <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1000000;
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(10'h048, 32'h0);
    rd(10'h04a, 32'h0);
    rd(10'h04b, 32'h0);
    rd(10'h040, 32'h0);
    wr(10'h049, 16'h0);
    rd(10'h048, 32'h1);
    repeat (1090) @(posedge clk_i);
    rd(10'h048, 32'h0);
    irq(1'h0);
    wr(10'h048, 16'h4);
    irq(1'h1);
    rd(10'h049, 32'h1);
    irq(1'h0);
    $display("test copy done");
    for (int i = 0; i < 4; i++) begin
      s = lfsr(s);
      ix = (i == 0) ? 14'h437 : 14'(s[15:0] % 1079);
      dv[i] = 14'(s[31:16] % 1080);
      wr(10'h04b, {2'h0, dv[i]});
      wr(10'h04a, {2'h0, ix});
      repeat (4) @(posedge clk_i);
      wr(10'h04a, {2'h2, ix});
      repeat (8) @(posedge clk_i);
      rd(10'h04b, {18'h2, dv[i]});
      rd(10'h04b, {18'h0, dv[i]});
    end
    wr(10'h04a, 16'hc438);
    repeat (8) @(posedge clk_i);
    rd(10'h04b, 32'h8000);
    $display("test ram done");
    wr(10'h048, 16'hc);
    ps_q <= 1'h1;
    col_q <= 11'h437;
    repeat (4) @(posedge clk_i);
    rd(10'h048, 32'he);
    irq(1'h1);
    rd(10'h049, 32'h2);
    frame;
    rd(10'h048, 32'hc);
    chk({31'h0, online_page_o}, 32'h1);
    rd(10'h049, 32'h2);
    chk({18'h0, src_slot_index_o}, {18'h0, dv[0]});
    row_q <= 4'h1;
    repeat (3) @(posedge clk_i);
    chk({18'h0, src_slot_index_o}, 32'h0);
    column_mode_i <= 1'h0;
    row_q <= 4'h9;
    repeat (3) @(posedge clk_i);
    chk({18'h0, src_slot_index_o}, 32'h0);
    column_mode_i <= 1'h1;
    $display("test swap done");
    wr(10'h048, 16'h1c);
    ps_q <= 1'h0;
    repeat (4) @(posedge clk_i);
    frame;
    rd(10'h048, 32'h1d);
    $display("test auto copy done");
    wrap_up;
  end
endmodule // testbench
bind outgoing_time_switch_memory osu_chk u_chk (.*);
